// ==== pkg/sysmgr_port_regs.vh ====
// Register offsets, field positions, reset values and response codes of the system manager port
`ifndef SYSMGR_PORT_REGS_VH
`define SYSMGR_PORT_REGS_VH
`define OFF_CONTROL       8'h00
`define OFF_STATUS        8'h04
`define OFF_STATUS_CLEAR  8'h08
`define OFF_ADDR          8'h0C
`define OFF_LENGTH        8'h10
`define OFF_DATA          8'h14
`define OFF_VERSION       8'h28
`define OFF_CHIP_ID       8'hF0
`define OFF_CHIP_ID_EXT   8'hF4
`define OFF_AP_IDENT      8'hFC
`define CTL_EN_BIT        0
`define CTL_SHUTDOWN_BIT  1
`define CTL_CRC_BIT       2
`define CTL_UPAGE_BIT     3
`define CTL_ERASE_BIT     4
`define ST_DONE_BIT       0
`define ST_HOLD_BIT       1
`define ST_BUSERR_BIT     2
`define ST_FAIL_BIT       3
`define ST_LCK_BIT        4
`define ST_EN_BIT         8
`define ST_PROT_BIT       9
`define ST_DBGP_BIT       10
`define ST_STATE_LSB      24
`define STATE_IDLE        3'h0
`define STATE_ERASE       3'h1
`define STATE_CRC         3'h2
`define STATE_UPAGE       3'h3
`define CRC_POLY          32'hEDB88320
`define REG_RESET         32'h00000000
`define AP_IDENT_VALUE    32'h00A50000 // Arbitrary identification value
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ==== src/crc32_word.v ====
// One 32-bit word folded into a reflected CRC32, one bit per loop stage
`timescale 1ns/10ps
`include "sysmgr_port_regs.vh"
module crc32_word (
  input  wire [31:0] crc_in,
  input  wire [31:0] data_in,
  output wire [31:0] crc_out
);
  wire [31:0] stage [0:32];
  assign stage[0] = crc_in ^ data_in;
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_bit
      // Reflected form: shift right, fold polynomial on the dropped bit
      assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ `CRC_POLY) : (stage[i] >> 1);
    end
  endgenerate
  assign crc_out = stage[32];
endmodule // crc32_word

// ==== src/sync2.v ====
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module sync2 (
  input  wire aclk,
  input  wire aresetn,
  input  wire clk_en,
  input  wire din,
  output reg  dout
);
  reg meta_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else if (clk_en) begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // sync2

// ==== src/system_manager_port.v ====
// System manager debug port: erase, core hold reset, user page read and CRC32
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "sysmgr_port_regs.vh"
// Notes on behaviour
// - Ignore all accesses until enable written
// - Disable clears every register but hold, stops engine
// - Operations run to end; disable or CRC bus error aborts
// - Protected: length register unreadable and unwritable
// - Protected and busy: address, data reads refused
// - Erase clears volatile, then flash, then protection
// - Erase bit starts erase; done flag on end
// - Debug reset request holds core in reset
// - Clear hold bit releases core reset when unprotected
// - Hold clear needs enable; reset pin clears
// - User page reads allowed while protected
// - Read bit fetches page word into data
// - Address bits beyond page silently dropped
// - Address advances one word after each read, wrapping within page
// - Reflected CRC32 with polynomial EDB88320
// - Final CRC left uninverted in data
// - Protected CRC forces whole flash range
// - CRC bit starts calculation; disable cancels
// - Done set at CRC end; check error flags
// - Status clear writes one clears, zero keeps
// - State field: 0 idle, 1 erase, 2 CRC, 3 read
module system_manager_port #(
  parameter PAGE_ADDR_W = 9,
  parameter FLASH_BASE  = 32'h00000000,
  parameter FLASH_SIZE  = 32'h00040000,
  parameter VERSION_VAL = 32'h00000100,
  parameter CHIP_ID_VAL = 32'h12345670, // Arbitrary identification value
  parameter CHIP_EXT_VAL = 32'h00000000 // Arbitrary identification value
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        debug_port_reset_request,
  input  wire        ext_reset_pin_n,
  input  wire        protected_in,
  input  wire        debugger_present,
  output reg         core_hold_reset,
  output reg         erase_volatile_req,
  input  wire        erase_volatile_done,
  output reg         erase_flash_req,
  input  wire        erase_flash_done,
  output reg         clear_protect_req,
  input  wire        clear_protect_done,
  output reg         mem_req,
  output reg  [31:0] mem_addr,
  input  wire        mem_ack,
  input  wire        mem_err,
  input  wire [31:0] mem_rdata,
  output reg         upage_req,
  output reg  [PAGE_ADDR_W-1:0] upage_addr,
  input  wire        upage_ack,
  input  wire [31:0] upage_rdata
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire hold_req_s, rst_pin_n_s, prot_s, dbgp_s;
  sync2 u_sync_hold (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .din(debug_port_reset_request), .dout(hold_req_s));
  sync2 u_sync_rstn (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .din(ext_reset_pin_n), .dout(rst_pin_n_s));
  sync2 u_sync_prot (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .din(protected_in), .dout(prot_s));
  sync2 u_sync_dbgp (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .din(debugger_present), .dout(dbgp_s));

  // ****************************************************************
  // State and registers
  // ****************************************************************
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_ERV   = 7'h02;
  localparam [6:0] S_ERF   = 7'h04;
  localparam [6:0] S_ERP   = 7'h08;
  localparam [6:0] S_CRC   = 7'h10;
  localparam [6:0] S_CRCW  = 7'h20;
  localparam [6:0] S_UPAGE = 7'h40;

  reg  [6:0]  state_r;
  reg         en_r;
  reg         done_r, hold_r, bus_error_flag_r, fail_r, lck_r;
  reg         hold_armed_r;
  reg  [31:0] addr_r, length_r, data_r;
  reg         aw_got_r, w_got_r;
  reg  [7:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  wire [31:0] crc_next;

  crc32_word u_crc (.crc_in(data_r), .data_in(mem_rdata), .crc_out(crc_next));

  wire busy      = (state_r != S_IDLE);
  wire wr_fire   = aw_got_r && w_got_r && !s_axi_bvalid;
  wire shut_wr   = wr_fire && (aw_addr_r == `OFF_CONTROL) && w_data_r[`CTL_SHUTDOWN_BIT];
  wire en_wr     = wr_fire && (aw_addr_r == `OFF_CONTROL) && w_data_r[`CTL_EN_BIT];
  wire reg_wr    = wr_fire && en_r && !shut_wr;
  wire ctl_wr    = reg_wr && (aw_addr_r == `OFF_CONTROL);
  wire clr_wr    = reg_wr && (aw_addr_r == `OFF_STATUS_CLEAR);
  wire addr_ok_w = !(prot_s && busy);
  wire [2:0] state_code = (state_r == S_CRC || state_r == S_CRCW) ? `STATE_CRC :
                          (state_r == S_UPAGE) ? `STATE_UPAGE :
                          (state_r == S_IDLE) ? `STATE_IDLE : `STATE_ERASE;
  wire [31:0] status_word = {5'h00, state_code, 13'h0000, dbgp_s, prot_s, en_r,
                             3'h0, lck_r, fail_r, bus_error_flag_r, hold_r, done_r};
  wire done_set = (state_r == S_ERP && clear_protect_done) ||
                  (state_r == S_CRCW && mem_ack && length_r == 32'h00000004) ||
                  (state_r == S_CRC && length_r == 32'h00000000) ||
                  (state_r == S_UPAGE && upage_ack);

  // ****************************************************************
  // AXI4-Lite slave and operation engine
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn || (clk_en && shut_wr)) begin
      state_r <= S_IDLE;
      en_r <= 1'b0;
      done_r <= 1'b0; bus_error_flag_r <= 1'b0; fail_r <= 1'b0; lck_r <= 1'b0;
      addr_r <= `REG_RESET; length_r <= `REG_RESET; data_r <= `REG_RESET;
      erase_volatile_req <= 1'b0; erase_flash_req <= 1'b0; clear_protect_req <= 1'b0;
      mem_req <= 1'b0; mem_addr <= 32'h00000000;
      upage_req <= 1'b0; upage_addr <= {PAGE_ADDR_W{1'b0}};
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      aw_got_r <= 1'b0; w_got_r <= 1'b0;
      aw_addr_r <= 8'h00; w_data_r <= 32'h00000000;
      s_axi_bvalid <= !aresetn ? 1'b0 : 1'b1;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000; s_axi_rresp <= `RESP_OKAY;
    end else if (clk_en) begin
      // Write channel: take address and data in either order
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (en_r || en_wr) ? `RESP_OKAY : `RESP_SLVERR;
        if (en_wr)
          en_r <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Read channel
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (!en_r) begin
          s_axi_rresp <= `RESP_SLVERR;
        end else begin
          case ({s_axi_araddr[7:2], 2'b00})
            `OFF_STATUS:      s_axi_rdata <= status_word;
            `OFF_ADDR:        if (addr_ok_w) s_axi_rdata <= addr_r;
                              else s_axi_rresp <= `RESP_SLVERR;
            `OFF_LENGTH:      if (!prot_s) s_axi_rdata <= length_r;
                              else s_axi_rresp <= `RESP_SLVERR;
            `OFF_DATA:        if (addr_ok_w) s_axi_rdata <= data_r;
                              else s_axi_rresp <= `RESP_SLVERR;
            `OFF_VERSION:     s_axi_rdata <= VERSION_VAL;
            `OFF_CHIP_ID:     s_axi_rdata <= CHIP_ID_VAL;
            `OFF_CHIP_ID_EXT: s_axi_rdata <= CHIP_EXT_VAL;
            `OFF_AP_IDENT:    s_axi_rdata <= `AP_IDENT_VALUE;
            `OFF_CONTROL, `OFF_STATUS_CLEAR: s_axi_rdata <= 32'h00000000;
            default:          s_axi_rresp <= `RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Register writes; operation state owns registers while busy
      if (reg_wr && !busy) begin
        if (aw_addr_r == `OFF_ADDR)
          addr_r <= {w_data_r[31:2], 2'b00};
        if (aw_addr_r == `OFF_LENGTH && !prot_s)
          length_r <= {w_data_r[31:2], 2'b00};
        if (aw_addr_r == `OFF_DATA)
          data_r <= w_data_r;
      end
      // Status clear: write one clears, set wins over clear
      if (clr_wr) begin
        if (w_data_r[`ST_DONE_BIT]) done_r <= 1'b0;
        if (w_data_r[`ST_BUSERR_BIT]) bus_error_flag_r <= 1'b0;
        if (w_data_r[`ST_FAIL_BIT]) fail_r <= 1'b0;
        if (w_data_r[`ST_LCK_BIT])  lck_r  <= 1'b0;
      end
      if (done_set)
        done_r <= 1'b1;
      if (ctl_wr && busy && (w_data_r[`CTL_ERASE_BIT] || w_data_r[`CTL_CRC_BIT] ||
          w_data_r[`CTL_UPAGE_BIT]))
        fail_r <= 1'b1;
      // Operation sequencer
      case (state_r)
        S_IDLE: begin
          if (ctl_wr && w_data_r[`CTL_ERASE_BIT]) begin
            state_r <= S_ERV;
            erase_volatile_req <= 1'b1;
          end else if (ctl_wr && w_data_r[`CTL_CRC_BIT]) begin
            state_r <= S_CRC;
            if (prot_s) begin
              addr_r <= FLASH_BASE;
              length_r <= FLASH_SIZE;
              data_r <= 32'hFFFFFFFF;
              lck_r <= 1'b1;
            end
          end else if (ctl_wr && w_data_r[`CTL_UPAGE_BIT]) begin
            state_r <= S_UPAGE;
            upage_req <= 1'b1;
            upage_addr <= addr_r[PAGE_ADDR_W+1:2];
          end
        end
        S_ERV: if (erase_volatile_done) begin
          erase_volatile_req <= 1'b0;
          erase_flash_req <= 1'b1;
          state_r <= S_ERF;
        end
        S_ERF: if (erase_flash_done) begin
          erase_flash_req <= 1'b0;
          clear_protect_req <= 1'b1;
          state_r <= S_ERP;
        end
        S_ERP: if (clear_protect_done) begin
          clear_protect_req <= 1'b0;
          state_r <= S_IDLE;
        end
        S_CRC: begin
          if (length_r == 32'h00000000) begin
            state_r <= S_IDLE;
          end else begin
            mem_req <= 1'b1;
            mem_addr <= addr_r;
            state_r <= S_CRCW;
          end
        end
        S_CRCW: begin
          if (mem_err) begin
            mem_req <= 1'b0;
            bus_error_flag_r <= 1'b1;
            done_r <= 1'b1;
            state_r <= S_IDLE;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            data_r <= crc_next;
            addr_r <= addr_r + 32'h00000004;
            length_r <= length_r - 32'h00000004;
            state_r <= (length_r == 32'h00000004) ? S_IDLE : S_CRC;
          end
        end
        S_UPAGE: if (upage_ack) begin
          upage_req <= 1'b0;
          data_r <= upage_rdata;
          addr_r <= {addr_r[31:PAGE_ADDR_W+2],
                     upage_addr + {{(PAGE_ADDR_W-1){1'b0}}, 1'b1}, 2'b00};
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Core hold reset, kept apart from disable
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= 1'b0;
      hold_armed_r <= 1'b1;
      core_hold_reset <= 1'b0;
    end else if (clk_en) begin
      // Clear beats a standing request and disarms until the reset pin
      if (!rst_pin_n_s) begin
        hold_r <= 1'b0;
        hold_armed_r <= 1'b1;
      end else if (clr_wr && w_data_r[`ST_HOLD_BIT] && !prot_s) begin
        hold_r <= 1'b0;
        hold_armed_r <= 1'b0;
      end else if (hold_req_s && hold_armed_r) begin
        hold_r <= 1'b1;
      end
      core_hold_reset <= hold_r;
    end
  end
endmodule // system_manager_port

// ==== test/far_side_model.sv ====
// Memory, user page and erase responders facing the system manager port
`timescale 1ns/10ps
module far_side_model #(parameter ERR_ADDR = 32'h00000200) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        mem_req,
  input  wire [31:0] mem_addr,
  output reg         mem_ack,
  output reg         mem_err,
  output reg  [31:0] mem_rdata,
  input  wire        upage_req,
  input  wire [8:0]  upage_addr,
  output reg         upage_ack,
  output reg  [31:0] upage_rdata,
  input  wire [2:0]  erase_req,
  output reg  [2:0]  erase_done
);
  integer   seed = 70999;
  reg [2:0] wait_r;
  wire      any_req = mem_req | upage_req | (|erase_req);
  wire      answered = mem_ack | mem_err | upage_ack | (|erase_done);
  // ************************************
  // One answer per request, random delay
  // ************************************
  always @(posedge aclk) begin
    mem_ack <= 1'h0;
    mem_err <= 1'h0;
    upage_ack <= 1'h0;
    erase_done <= 3'h0;
    mem_rdata <= ~mem_rdata;
    upage_rdata <= ~upage_rdata;
    if (!aresetn) begin
      wait_r <= 3'h0;
      mem_rdata <= 32'h0;
      upage_rdata <= 32'h0;
    end else if (any_req && !answered) begin
      if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end else begin
        wait_r <= 3'($random(seed));
        mem_err <= mem_req && mem_addr == ERR_ADDR;
        mem_ack <= mem_req && mem_addr != ERR_ADDR;
        mem_rdata <= mem_addr * 32'h9E3779B1;
        upage_ack <= upage_req;
        upage_rdata <= 32'hC0DE0000 ^ upage_addr;
        erase_done <= erase_req;
      end
    end
  end
endmodule // far_side_model

// ==== test/smp_checker_assertions.sv ====
// Concurrent checks on the system manager port boundary
`timescale 1ns/10ps
module smp_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        clk_en,
  input wire        s_axi_wvalid,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        protected_in,
  input wire        erase_volatile_req,
  input wire        erase_volatile_done,
  input wire        erase_flash_req,
  input wire        clear_protect_req,
  input wire        mem_req,
  input wire [31:0] mem_addr,
  input wire        mem_ack,
  input wire        mem_err
);
  reg rd_stat_r;
  reg vol_ok_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_stat_r <= 1'h0;
      vol_ok_r <= 1'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_stat_r <= s_axi_araddr == 8'h04;
      if (erase_volatile_req) vol_ok_r <= erase_volatile_done;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  mem_hold_a:
    assert property (mem_req && !mem_ack && !mem_err && !s_axi_wvalid && !$past(s_axi_wvalid)
      && !$past(s_axi_wvalid, 2) |=> mem_req && $stable(mem_addr)) else $error("fetch dropped");
  fault_stop_a:
    assert property (mem_req && mem_err |=> !mem_req [*2]) else $error("fetch after bus error");
  fetch_step_a:
    assert property (mem_req && mem_ack |=> ##1
      (!mem_req || mem_addr == $past(mem_addr, 2) + 32'h4)) else $error("fetch address not stepped");
  len_locked_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10 && protected_in
      && $past(protected_in, 4) |=> s_axi_rvalid && s_axi_rresp == 2'h2)
      else $error("length read not refused");
  busy_read_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14 && protected_in
      && mem_req |=> s_axi_rvalid && s_axi_rresp == 2'h2) else $error("busy data read allowed");
  state_legal_a:
    assert property (s_axi_rvalid && rd_stat_r && s_axi_rresp == 2'h0
      |-> s_axi_rdata[26:24] < 3'h4 && s_axi_rdata[23:11] == 13'h0) else $error("bad status");
  erase_order_a:
    assert property ($rose(erase_flash_req) |-> vol_ok_r) else $error("flash erased too early");
  protect_last_a:
    assert property (clear_protect_req |-> !erase_flash_req && !erase_volatile_req)
      else $error("protection cleared too early");
endmodule // smp_checker
bind system_manager_port smp_checker chk (.aclk, .aresetn, .clk_en, .s_axi_wvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .protected_in, .erase_volatile_req, .erase_volatile_done, .erase_flash_req,
  .clear_protect_req, .mem_req, .mem_addr, .mem_ack, .mem_err);

// ==== test/tb_top.sv ====
// Self-checking bench for the system manager port
`timescale 1ns/10ps
`include "sysmgr_port_regs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
  localparam ERR_ADDR = 32'h00000200;
  reg         aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, debugger_present = 1'h1;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg  [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         debug_port_reset_request = 1'h0, ext_reset_pin_n = 1'h1, protected_in = 1'h0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, mem_addr, mem_rdata, upage_rdata;
  wire        core_hold_reset, erase_volatile_req, erase_volatile_done, erase_flash_req;
  wire        erase_flash_done, clear_protect_req, clear_protect_done;
  wire        mem_req, mem_ack, mem_err, upage_req, upage_ack;
  wire [8:0]  upage_addr;
  integer     n_mismatch = 0, comparisons = 0, seed = 70999, i, k, n;
  reg  [31:0] a, d, s, crc;
  system_manager_port #(.FLASH_SIZE(32'h20)) dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .debug_port_reset_request,
    .ext_reset_pin_n, .protected_in, .debugger_present, .core_hold_reset, .erase_volatile_req,
    .erase_volatile_done, .erase_flash_req, .erase_flash_done, .clear_protect_req,
    .clear_protect_done, .mem_req, .mem_addr, .mem_ack, .mem_err, .mem_rdata, .upage_req,
    .upage_addr, .upage_ack, .upage_rdata);
  far_side_model #(.ERR_ADDR(ERR_ADDR)) mdl (.aclk, .aresetn, .mem_req, .mem_addr, .mem_ack,
    .mem_err, .mem_rdata, .upage_req, .upage_addr, .upage_ack, .upage_rdata,
    .erase_req({clear_protect_req, erase_flash_req, erase_volatile_req}),
    .erase_done({clear_protect_done, erase_flash_done, erase_volatile_done}));
  always #4 aclk = ~aclk;
  // *******************************
  // Bus tasks and expected values
  // *******************************
  function automatic [31:0] fold(input [31:0] c, input [31:0] w);
    integer b;
    begin
      fold = c ^ w;
      for (b = 0; b < 32; b++) fold = fold[0] ? (fold >> 1) ^ `CRC_POLY : fold >> 1;
    end
  endfunction
  function automatic [31:0] st(input p, input [4:0] lo);
    st = {21'h0, debugger_present, p, 1'h1, 3'h0, lo};
  endfunction
  task automatic wr(input [7:0] ad, input [31:0] dt, input [1:0] er);
    integer t;
    begin
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      t = 0;
      while (t == 0) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_bvalid) begin
          `CHK("bresp", er, s_axi_bresp)
          t = 1;
        end
      end
      s_axi_bready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task automatic rd(input [7:0] ad, input [1:0] er, output [31:0] v);
    integer t;
    begin
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      t = 0;
      while (t == 0) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid) begin
          v = s_axi_rdata;
          `CHK("rresp", er, s_axi_rresp)
          t = 1;
        end
      end
      s_axi_rready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task automatic rc(input [7:0] ad, input [1:0] er, input [31:0] e);
    reg [31:0] v;
    begin
      rd(ad, er, v);
      `CHK("rdata", e, v)
    end
  endtask
  task automatic go(input [31:0] cmd);
    begin
      // Lock bit kept so a protected start stays visible
      wr(`OFF_STATUS_CLEAR, 32'h0D, `RESP_OKAY);
      wr(`OFF_CONTROL, cmd, `RESP_OKAY);
      s = 32'h0;
      while (s[0] !== 1'h1) rd(`OFF_STATUS, `RESP_OKAY, s);
    end
  endtask
  task report_and_stop;
    begin
      if (n_mismatch == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rc(`OFF_STATUS, `RESP_SLVERR, 32'h0);
    wr(`OFF_ADDR, 32'h40, `RESP_SLVERR);
    wr(`OFF_CONTROL, 32'h1, `RESP_OKAY);
    rc(`OFF_ADDR, `RESP_OKAY, 32'h0);
    rd(8'h30, `RESP_SLVERR, d);
    crc = 32'hFFFFFFFF;
    for (i = 0; i < 3; i++) begin
      a = 32'h100 + ($random(seed) & 32'h7C);
      n = ($random(seed) & 7) + 1;
      wr(`OFF_ADDR, a, `RESP_OKAY);
      wr(`OFF_LENGTH, n * 4, `RESP_OKAY);
      wr(`OFF_DATA, crc, `RESP_OKAY);
      go(32'h4);
      for (k = 0; k < n; k++) crc = fold(crc, (a + 4 * k) * 32'h9E3779B1);
      rc(`OFF_DATA, `RESP_OKAY, crc);
      rc(`OFF_STATUS, `RESP_OKAY, st(1'h0, 5'h01));
    end
    wr(`OFF_ADDR, ERR_ADDR - 4, `RESP_OKAY);
    wr(`OFF_LENGTH, 32'h10, `RESP_OKAY);
    go(32'h4);
    rc(`OFF_STATUS, `RESP_OKAY, st(1'h0, 5'h05));
    wr(`OFF_STATUS_CLEAR, 32'h0, `RESP_OKAY);
    rc(`OFF_STATUS, `RESP_OKAY, st(1'h0, 5'h05));
    wr(`OFF_STATUS_CLEAR, 32'h5, `RESP_OKAY);
    rc(`OFF_STATUS, `RESP_OKAY, st(1'h0, 5'h00));
    wr(`OFF_ADDR, 32'h010007FC, `RESP_OKAY);
    go(32'h8);
    rc(`OFF_DATA, `RESP_OKAY, 32'hC0DE01FF);
    go(32'h8);
    rc(`OFF_DATA, `RESP_OKAY, 32'hC0DE0000);
    go(32'h10);
    rc(`OFF_STATUS, `RESP_OKAY, st(1'h0, 5'h01));
    protected_in <= 1'h1;
    repeat (6) @(posedge aclk);
    rd(`OFF_LENGTH, `RESP_SLVERR, d);
    wr(`OFF_ADDR, 32'h0, `RESP_OKAY);
    go(32'h8);
    rc(`OFF_DATA, `RESP_OKAY, 32'hC0DE0000);
    wr(`OFF_DATA, 32'h1234, `RESP_OKAY);
    wr(`OFF_STATUS_CLEAR, 32'h1D, `RESP_OKAY);
    wr(`OFF_CONTROL, 32'h4, `RESP_OKAY);
    rd(`OFF_DATA, `RESP_SLVERR, d);
    go(32'h8);
    crc = 32'hFFFFFFFF;
    for (k = 0; k < 8; k++) crc = fold(crc, (4 * k) * 32'h9E3779B1);
    rc(`OFF_DATA, `RESP_OKAY, crc);
    rc(`OFF_STATUS, `RESP_OKAY, st(1'h1, 5'h19));
    protected_in <= 1'h0;
    debug_port_reset_request <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("hold", 1'h1, core_hold_reset)
    wr(`OFF_CONTROL, 32'h2, `RESP_OKAY);
    wr(`OFF_STATUS_CLEAR, 32'h2, `RESP_SLVERR);
    wr(`OFF_CONTROL, 32'h1, `RESP_OKAY);
    `CHK("hold", 1'h1, core_hold_reset)
    wr(`OFF_STATUS_CLEAR, 32'h2, `RESP_OKAY);
    repeat (8) @(posedge aclk);
    `CHK("hold", 1'h0, core_hold_reset)
    clk_en <= 1'h0;
    ext_reset_pin_n <= 1'h0;
    repeat (4) @(posedge aclk);
    ext_reset_pin_n <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("frozen", 1'h0, core_hold_reset)
    clk_en <= 1'h1;
    ext_reset_pin_n <= 1'h0;
    repeat (4) @(posedge aclk);
    ext_reset_pin_n <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("hold", 1'h1, core_hold_reset)
    debug_port_reset_request <= 1'h0;
    wr(`OFF_STATUS_CLEAR, 32'h2, `RESP_OKAY);
    wr(`OFF_ADDR, 32'h100, `RESP_OKAY);
    wr(`OFF_LENGTH, 32'h100, `RESP_OKAY);
    wr(`OFF_CONTROL, 32'h4, `RESP_OKAY);
    wr(`OFF_CONTROL, 32'h2, `RESP_OKAY);
    `CHK("mem_req", 1'h0, mem_req)
    rc(`OFF_STATUS, `RESP_SLVERR, 32'h0);
    wr(`OFF_CONTROL, 32'h1, `RESP_OKAY);
    rc(`OFF_ADDR, `RESP_OKAY, 32'h0);
    rc(`OFF_LENGTH, `RESP_OKAY, 32'h0);
    rc(`OFF_DATA, `RESP_OKAY, 32'h0);
    rc(`OFF_STATUS, `RESP_OKAY, st(1'h0, 5'h00));
    report_and_stop();
  end
endmodule // tb_top
